/* File: src/hgf_top.sv */
// Purpose: Transmit framer with interframe flag gap control and frame counter
// Assumes: APB slave, one clock; byte stream in through a FIFO, byte stream out
// Notes: Gap flags go out only when the mapper takes them, so a stall stretches the gap
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
module hgf_top
  import hgf_pkg::*;
#(
  parameter int LEN_W = 16,
  parameter int GAP_W = 24,
  parameter int FIFO_DEPTH = HGF_FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [HGF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic in_abort,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_fill
);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  typedef struct packed {
    hgf_state_t st;
    logic [15:0] gap_ctrl;
    logic [15:0] link_ctrl;
    logic [HGF_CNT_W-1:0] cnt;
    logic [HGF_CNT_W-1:0] hold;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] esc;
    logic [GAP_W-1:0] gap_left;
    logic [7:0] pend;
    logic done;
    logic ov;
    logic [7:0] od;
    logic ofill;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hgf_top_t;

  hgf_top_t s_reg;
  hgf_top_t s_next;
  logic f_valid;
  logic f_pop;
  logic [9:0] f_word;
  logic [LW-1:0] f_level;
  logic [GAP_W-1:0] gap;
  logic gap_valid;
  logic slot;
  logic go_data;
  logic cnt_inc;
  logic acc;
  logic commit;
  logic [8:0] dec_acc;
  logic [8:0] dec_com;
  logic [7:0] b;

  // Decode a byte address to {hit, index}; misaligned or out-of-map is a miss
  function automatic logic [8:0] hgf_decode(input logic [HGF_ADDR_W-1:0] a);
    logic [7:0] idx;
    logic hit;
    idx = a[9:2];
    hit = (a[1:0] == 2'b00) && (a[HGF_ADDR_W-1:10] == '0)
      && (idx >= HGF_IDX_LINK_CTRL) && (idx <= HGF_IDX_CNT_HI);
    return {hit, idx};
  endfunction : hgf_decode

  hgf_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({in_abort, in_last, in_data}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_word),
    .level(f_level)
  );

  hgf_gap_calc #(
    .LEN_W(LEN_W),
    .GAP_W(GAP_W)
  ) u_gap (
    .pclk(pclk),
    .presetn(presetn),
    .done(s_reg.done),
    .len(s_reg.len),
    .esc(s_reg.esc),
    .ctrl(s_reg.gap_ctrl),
    .gap(gap),
    .gap_valid(gap_valid)
  );

  // Framer, counter and register file in one next-state process
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    f_pop = 1'b0;
    cnt_inc = 1'b0;
    b = f_word[7:0];
    // Output register reloads when empty or when the mapper takes its byte
    slot = !s_reg.ov || out_ready;
    if (slot) begin
      s_next.ov = 1'b0;
    end
    // A new packet starts only while reading is enabled
    go_data = ((s_reg.st == ST_IDLE) && s_reg.link_ctrl[HGF_RD_EN_BIT])
      || (s_reg.st == ST_DATA);
    case (s_reg.st)
      ST_IDLE, ST_DATA: begin
        if (slot && go_data && f_valid) begin
          s_next.ov = 1'b1;
          s_next.ofill = 1'b0;
          if (s_reg.st == ST_IDLE) begin
            s_next.len = '0;
            s_next.esc = '0;
          end
          if (f_word[9]) begin
            // Abort: escape then the following gap flag closes the sequence
            s_next.od = HGF_ESC;
            f_pop = 1'b1;
            s_next.done = 1'b1;
            s_next.st = ST_CALC;
          end else if (b == HGF_FLAG || b == HGF_ESC) begin
            s_next.od = HGF_ESC;
            s_next.pend = b ^ HGF_ESC_XOR;
            s_next.esc = ((s_reg.st == ST_IDLE) ? '0 : s_reg.esc) + 1'b1;
            s_next.st = ST_ESC2;
          end else begin
            s_next.od = b;
            f_pop = 1'b1;
            s_next.len = ((s_reg.st == ST_IDLE) ? '0 : s_reg.len) + 1'b1;
            s_next.st = f_word[8] ? ST_CALC : ST_DATA;
            s_next.done = f_word[8];
            cnt_inc = f_word[8];
          end
        end else if (slot && s_reg.st == ST_IDLE) begin
          // Idle line carries fill flags
          s_next.ov = 1'b1;
          s_next.od = HGF_FLAG;
          s_next.ofill = 1'b1;
        end
      end
      // Second half of an escape; the FIFO head is popped only now
      ST_ESC2: begin
        if (slot) begin
          s_next.ov = 1'b1;
          s_next.od = s_reg.pend;
          s_next.ofill = 1'b0;
          f_pop = 1'b1;
          s_next.len = s_reg.len + 1'b1;
          s_next.st = f_word[8] ? ST_CALC : ST_DATA;
          s_next.done = f_word[8];
          cnt_inc = f_word[8];
        end
      end
      ST_CALC: begin
        // Wait for the gap result; no new byte is loaded meanwhile
        if (gap_valid) begin
          s_next.gap_left = gap;
          s_next.st = ST_GAP;
        end
      end
      // Count the gap down; the last flag hands the line back to idle
      ST_GAP: begin
        if (slot) begin
          s_next.ov = 1'b1;
          s_next.od = HGF_FLAG;
          s_next.ofill = 1'b1;
          s_next.gap_left = s_reg.gap_left - 1'b1;
          if (s_reg.gap_left <= GAP_W'(1)) begin
            s_next.st = ST_IDLE;
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    // A frame is counted on the pop of its last word, never on an abort
    if (cnt_inc) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
    // APB: prepare answer on the first access cycle, commit writes at completion
    acc = psel && penable && !s_reg.pready;
    commit = psel && penable && s_reg.pready;
    dec_acc = hgf_decode(paddr);
    dec_com = hgf_decode(paddr);
    s_next.pready = acc;
    s_next.pslverr = 1'b0;
    if (acc) begin
      s_next.prdata = 32'h00000000;
      s_next.pslverr = !dec_acc[8];
      if (dec_acc[8] && !pwrite) begin
        if (dec_acc[7:0] == HGF_IDX_LINK_CTRL) begin
          s_next.prdata[15:0] = s_reg.link_ctrl;
          s_next.prdata[HGF_LEVEL_LSB +: LW] = f_level;
          s_next.prdata[HGF_BUSY_BIT] = (s_reg.st != ST_IDLE);
        end else if (dec_acc[7:0] == HGF_IDX_GAP_CTRL) begin
          s_next.prdata[15:0] = s_reg.gap_ctrl;
        end else if (dec_acc[7:0] == HGF_IDX_CNT_LO) begin
          s_next.prdata[15:0] = s_reg.hold[15:0];
        end else begin
          s_next.prdata[10:0] = s_reg.hold[26:16];
        end
      end
    end
    if (commit && pwrite && dec_com[8]) begin
      if (dec_com[7:0] == HGF_IDX_LINK_CTRL) begin
        s_next.link_ctrl = pwdata[15:0] & HGF_LINK_CTRL_MASK;
      end else if (dec_com[7:0] == HGF_IDX_GAP_CTRL) begin
        s_next.gap_ctrl = pwdata[15:0] & HGF_GAP_CTRL_MASK;
      end else if (dec_com[7:0] == HGF_IDX_CNT_HI) begin
        // Snapshot and clear; a frame finishing in the same cycle is kept
        s_next.hold = s_reg.cnt;
        s_next.cnt = cnt_inc ? HGF_CNT_W'(1) : HGF_CNT_RESET;
      end
    end
  end

  // Registered state; every top-level output except in_ready is read from here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.gap_ctrl <= HGF_GAP_CTRL_RESET;
      s_reg.link_ctrl <= HGF_LINK_CTRL_RESET;
      s_reg.cnt <= HGF_CNT_RESET;
      s_reg.hold <= HGF_CNT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state flops
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign out_valid = s_reg.ov;
  assign out_data = s_reg.od;
  assign out_fill = s_reg.ofill;

  default clocking hgf_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  gap_nonzero_a: assert property (
    s_reg.st == ST_GAP && $past(s_reg.st) != ST_GAP |-> s_reg.gap_left != '0)
    else $error("gap entered with zero flags");
  snap_copy_a: assert property (
    commit && pwrite && dec_com[8] && dec_com[7:0] == HGF_IDX_CNT_HI
    |=> s_reg.hold == $past(s_reg.cnt) && s_reg.cnt <= HGF_CNT_W'(1))
    else $error("snapshot did not copy and clear");
  snap_high_a: assert property (
    acc && !pwrite && dec_acc == {1'b1, HGF_IDX_CNT_HI}
    |=> pready && prdata == {21'h000000, s_reg.hold[26:16]})
    else $error("upper word read wrong");
  read_off_a: assert property (
    s_reg.st == ST_IDLE && !s_reg.link_ctrl[HGF_RD_EN_BIT] |-> !f_pop
    ##1 s_reg.st == ST_IDLE)
    else $error("packet read while reading disabled");
  abort_skip_a: assert property (
    f_pop && f_word[9] && !(commit && pwrite) |=> s_reg.cnt == $past(s_reg.cnt))
    else $error("aborted frame counted");
  frame_count_a: assert property (
    f_pop && f_word[8] && !f_word[9] && !(commit && pwrite)
    |=> s_reg.cnt == $past(s_reg.cnt) + 1'b1)
    else $error("finished frame not counted");
  gap_load_a: assert property (
    s_reg.done |-> s_reg.st == ST_CALC ##1 gap_valid ##1 s_reg.st == ST_GAP
    && s_reg.gap_left == $past(gap))
    else $error("gap not loaded after frame end");
  esc_first_a: assert property (
    s_reg.st == ST_ESC2 && $past(s_reg.st) != ST_ESC2 |-> s_reg.ov && s_reg.od == HGF_ESC)
    else $error("escape byte missing");
  gap_flags_a: assert property (
    s_reg.st == ST_GAP && slot |=> s_reg.ov && s_reg.od == HGF_FLAG && s_reg.ofill)
    else $error("non-flag byte in gap");

  // The gap is sent flag by flag and holds while the mapper stalls
  gap_step_a: assert property (
    s_reg.st == ST_GAP && slot && s_reg.gap_left > GAP_W'(1)
    |=> s_reg.st == ST_GAP && s_reg.gap_left == $past(s_reg.gap_left) - 1'b1)
    else $error("gap count did not step down");
  gap_end_a: assert property (
    s_reg.st == ST_GAP && slot && s_reg.gap_left <= GAP_W'(1) |=> s_reg.st == ST_IDLE)
    else $error("gap did not end after its last flag");
  gap_hold_a: assert property (
    s_reg.st == ST_GAP && !slot |=> s_reg.st == ST_GAP && $stable(s_reg.gap_left))
    else $error("gap count moved during a stall");
  calc_quiet_a: assert property (
    s_reg.st == ST_CALC |-> !f_pop)
    else $error("packet read while the gap is worked out");
  fill_idle_a: assert property (
    s_reg.st == ST_IDLE && !s_reg.link_ctrl[HGF_RD_EN_BIT] && slot
    |=> s_reg.ov && s_reg.od == HGF_FLAG && s_reg.ofill)
    else $error("idle line with reading off sent a non-flag");
  abort_end_a: assert property (
    f_pop && f_word[9] |=> s_reg.st == ST_CALC && s_reg.done && s_reg.od == HGF_ESC)
    else $error("abort not closed by an escape");

  // The counter moves only for finished frames or a snapshot
  cnt_hold_a: assert property (
    !cnt_inc && !(commit && pwrite) |=> $stable(s_reg.cnt))
    else $error("frame counter moved without a frame");
  low_read_a: assert property (
    acc && !pwrite && dec_acc == {1'b1, HGF_IDX_CNT_LO}
    |=> pready && prdata == {16'h0000, s_reg.hold[15:0]})
    else $error("lower word read wrong");
  ctrl_write_a: assert property (
    commit && pwrite && dec_com == {1'b1, HGF_IDX_GAP_CTRL}
    |=> s_reg.gap_ctrl == ($past(pwdata[15:0]) & HGF_GAP_CTRL_MASK))
    else $error("gap control write lost");
endmodule : hgf_top

/* File: src/hgf_pkg.sv */
// Purpose: Shared constants and types for the transmit gap flow-control block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Field positions refer to the 16-bit register images
package hgf_pkg;
  // Register word indices
  localparam logic [7:0] HGF_IDX_LINK_CTRL = 8'h40;
  localparam logic [7:0] HGF_IDX_GAP_CTRL = 8'h41;
  localparam logic [7:0] HGF_IDX_CNT_LO = 8'h42;
  localparam logic [7:0] HGF_IDX_CNT_HI = 8'h43;
  localparam int HGF_ADDR_W = 12;
  // Gap control fields
  localparam int HGF_PROP_EN_BIT = 14;
  localparam int HGF_PROP_MUL_BIT = 13;
  localparam int HGF_SCALE_LSB = 10;
  localparam int HGF_FIX_EN_BIT = 9;
  localparam int HGF_FIX_X256_BIT = 8;
  localparam logic [15:0] HGF_GAP_CTRL_RESET = 16'h0401;
  localparam logic [15:0] HGF_GAP_CTRL_MASK = 16'h7FFF;
  // Link control fields
  localparam int HGF_RD_EN_BIT = 6;
  localparam logic [15:0] HGF_LINK_CTRL_RESET = 16'h0040;
  localparam logic [15:0] HGF_LINK_CTRL_MASK = 16'h0040;
  localparam int HGF_LEVEL_LSB = 8;
  localparam int HGF_BUSY_BIT = 12;
  // Frame counter
  localparam int HGF_CNT_W = 27;
  localparam logic [26:0] HGF_CNT_RESET = 27'h0000000;
  // Fixed gap values that a zero field stands for, and the x256 shift
  localparam int HGF_FIX_ZERO_X1 = 256;
  localparam int HGF_FIX_ZERO_X256 = 65536;
  localparam int HGF_FIX_SHIFT = 8;
  // Line bytes, FIFO depth and framer states
  localparam logic [7:0] HGF_FLAG = 8'h7E;
  localparam logic [7:0] HGF_ESC = 8'h7D;
  localparam logic [7:0] HGF_ESC_XOR = 8'h20;
  localparam int HGF_FIFO_DEPTH = 8;
  typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_ESC2, ST_CALC, ST_GAP} hgf_state_t;
endpackage : hgf_pkg

/* File: src/hgf_fifo.sv */
// Purpose: Small first-word-fall-through FIFO for the transmit byte path
// Assumes: Single clock, pop only when out_valid is high
// Notes: Full and empty are kept as flops so the ports come straight from registers
`timescale 1ns/1ns
module hgf_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic full;
    logic empty;
  } hgf_fifo_t;
  hgf_fifo_t s_reg;
  hgf_fifo_t s_next;
  logic push;
  logic pop;

  // Pointer and flag update; full and empty follow the next count
  always_comb begin
    s_next = s_reg;
    push = in_valid && !s_reg.full;
    pop = out_ready && !s_reg.empty;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = (s_reg.wp == AW'(DEPTH-1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(DEPTH-1)) ? '0 : s_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
    s_next.full = (s_next.cnt == CW'(DEPTH));
    s_next.empty = (s_next.cnt == '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.empty <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready = !s_reg.full;
  assign out_valid = !s_reg.empty;
  assign out_data = s_reg.mem[s_reg.rp];
  assign level = s_reg.cnt;
endmodule : hgf_fifo

/* File: src/hgf_gap_calc.sv */
// Purpose: Works out the interframe flag count once per finished or aborted frame
// Assumes: Length and escape counts are stable while done is high
// Notes: Result appears one cycle after done, marked by a one-cycle valid
`timescale 1ns/1ns
module hgf_gap_calc
  import hgf_pkg::*;
#(
  parameter int LEN_W = 16,
  parameter int GAP_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic done,
  input wire logic [LEN_W-1:0] len,
  input wire logic [LEN_W-1:0] esc,
  input wire logic [15:0] ctrl,
  output logic [GAP_W-1:0] gap,
  output logic gap_valid
);
  typedef struct packed {
    logic [GAP_W-1:0] gap;
    logic valid;
  } hgf_gap_t;
  hgf_gap_t s_reg;
  hgf_gap_t s_next;
  logic [GAP_W-1:0] m1w;
  logic [GAP_W-1:0] m1;
  logic [GAP_W-1:0] m2;
  logic [GAP_W-1:0] best;
  logic [2:0] scale;
  logic [7:0] fix_val;

  // Both methods are evaluated; a disabled one contributes nothing to the maximum
  always_comb begin
    s_next = s_reg;
    scale = ctrl[HGF_SCALE_LSB +: 3];
    fix_val = ctrl[7:0];
    if (ctrl[HGF_PROP_MUL_BIT]) begin
      m1w = GAP_W'(len) << scale;
    end else begin
      m1w = GAP_W'(len) >> scale;
      if (m1w == '0) begin
        m1w = GAP_W'(1);
      end
    end
    // Escapes already act as fill, so they are taken off the proportional count
    m1 = (m1w > GAP_W'(esc)) ? m1w - GAP_W'(esc) : '0;
    if (ctrl[HGF_FIX_X256_BIT]) begin
      m2 = (fix_val == 8'h00) ? GAP_W'(HGF_FIX_ZERO_X256) : GAP_W'(fix_val) << HGF_FIX_SHIFT;
    end else begin
      m2 = (fix_val == 8'h00) ? GAP_W'(HGF_FIX_ZERO_X1) : GAP_W'(fix_val);
    end
    best = GAP_W'(1);
    if (ctrl[HGF_PROP_EN_BIT] && m1 > best) begin
      best = m1;
    end
    if (ctrl[HGF_FIX_EN_BIT] && m2 > best) begin
      best = m2;
    end
    s_next.valid = done;
    if (done) begin
      s_next.gap = best;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign gap = s_reg.gap;
  assign gap_valid = s_reg.valid;

  fix_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !ctrl[HGF_PROP_EN_BIT] && ctrl[HGF_FIX_EN_BIT] && !ctrl[HGF_FIX_X256_BIT]
    && ctrl[7:0] == 8'h00 |=> gap == GAP_W'(256) && gap_valid)
    else $error("fixed zero gap is not 256 flags");
  fix_wide_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !ctrl[HGF_PROP_EN_BIT] && ctrl[HGF_FIX_EN_BIT] && ctrl[HGF_FIX_X256_BIT]
    |=> gap == (($past(ctrl[7:0]) == 8'h00) ? GAP_W'(65536) : GAP_W'($past(ctrl[7:0])) * 256))
    else $error("wide fixed gap count wrong");
  prop_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && ctrl[HGF_PROP_EN_BIT] && !ctrl[HGF_FIX_EN_BIT] && !ctrl[HGF_PROP_MUL_BIT]
    && esc == '0 |=> gap == ((($past(len) >> $past(scale)) == '0) ? GAP_W'(1)
    : GAP_W'($past(len) >> $past(scale))))
    else $error("divided gap count wrong");
  prop_mul_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && ctrl[HGF_PROP_EN_BIT] && !ctrl[HGF_FIX_EN_BIT] && ctrl[HGF_PROP_MUL_BIT]
    && esc == '0 && len != '0 |=> gap == GAP_W'($past(len)) * (GAP_W'(1) << $past(scale)))
    else $error("multiplied gap count wrong");
  no_method_a: assert property (@(posedge pclk) disable iff (!presetn)
    done && !ctrl[HGF_PROP_EN_BIT] && !ctrl[HGF_FIX_EN_BIT] |=> gap == GAP_W'(1))
    else $error("gap inserted with both methods off");
endmodule : hgf_gap_calc

/* File: tb/hgf_mapper.sv */
// Purpose: Payload mapper model that takes the framed byte stream
// Assumes: A byte is taken when out_valid and out_ready are high at a rising edge
// Notes: Random stalls make the bench count gaps in taken bytes, not cycles
`timescale 1ns/1ns
module hgf_mapper (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall_en,
  output logic out_ready
);
  int seed = 15794;
  // Ready moves only after an edge, so a byte is never half taken
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) out_ready <= 1'h0;
    else out_ready <= stall_en ? ($random(seed) % 2 != 0) : 1'h1;
  end
endmodule : hgf_mapper

/* File: tb/hgf_top_tb.sv */
// Purpose: Self-checking bench for the gap flow-control framer
// Assumes: APB byte address is four times the register index
// Notes: A gap is the number of fill bytes taken between two frames
`timescale 1ns/1ns
module hgf_top_tb;
  import hgf_pkg::*;
  localparam int GAPN = 1000000;
  localparam int ANY = 2000000;
  localparam logic [15:0] CFG [9] = '{16'h0000, 16'h4000, 16'h4C00, 16'h0205, 16'h0200,
    16'h0301, 16'h4A07, 16'h0206, 16'h6000};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, in_valid = 1'h0, in_ready, in_last = 1'h0, in_abort = 1'h0;
  logic [7:0] in_data = 8'h0, out_data;
  logic out_valid, out_ready, out_fill, stall_en = 1'h0;
  int err_total = 0, checked = 0, seed = 15794, run = 0, sent = 0;
  int exp_q[$];

  hgf_top hgf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_last(in_last), .in_abort(in_abort), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_fill(out_fill));
  hgf_mapper hgf_mapper_inst (.pclk(pclk), .presetn(presetn), .stall_en(stall_en),
    .out_ready(out_ready));

  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end

  task give_verdict;
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task hang(input string what);
    err_total++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    give_verdict();
  endtask : hang

  // One APB transfer, held until pready is seen high at an edge
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (n == 20) hang("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, idx, {16'h0, d}, r, e);
  endtask : wr

  task rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp,
    input logic eerr);
    logic [31:0] r;
    logic e;
    apb(1'h0, idx, 32'h0, r, e);
    chk(what, exp, r);
    chk("pslverr", {31'h0, eerr}, {31'h0, e});
  endtask : rd_chk

  // Flags expected after a frame of l bytes holding e stuffed bytes
  function int gap_of(input logic [15:0] c, input int l, input int e);
    int m1, m2;
    m1 = 0;
    m2 = 0;
    if (c[14]) m1 = (c[13] ? l << c[12:10] : l >> c[12:10]) - e;
    if (c[9]) m2 = (c[7:0] == 8'h0) ? (c[8] ? 65536 : 256) : (c[8] ? c[7:0] * 256 : c[7:0]);
    return (m1 > m2) ? ((m1 > 1) ? m1 : 1) : ((m2 > 1) ? m2 : 1);
  endfunction : gap_of

  task push(input logic [7:0] d, input logic l, input logic a);
    int n;
    in_valid <= 1'h1;
    in_data <= d;
    in_last <= l;
    in_abort <= a;
    for (n = 0; n < 5000; n++) begin
      @(posedge pclk);
      if (in_ready === 1'h1) break;
    end
    if (n == 5000) hang("in_ready");
  endtask : push

  // Sends one packet and notes the line bytes and the gap that follow it
  task send(input int len, input logic ab, input logic [15:0] ctl, input logic keep);
    int i, e;
    logic [7:0] b;
    e = 0;
    for (i = 0; i < len; i++) begin
      // Four-byte frames keep random bytes so the escape-free gap checks are reached
      b = (len != 4 && i == 1) ? 8'h7E : (len != 4 && i == 2) ? 8'h7D : 8'($random(seed));
      if (b == 8'h7E || b == 8'h7D) begin
        e++;
        exp_q.push_back(8'h7D);
        exp_q.push_back(b ^ 8'h20);
      end else exp_q.push_back(b);
      push(b, i == len - 1 && !ab, 1'h0);
    end
    if (ab) begin
      push(8'h0, 1'h0, 1'h1);
      exp_q.push_back(8'h7D);
    end
    exp_q.push_back((keep && !ab) ? GAPN + gap_of(ctl, len, e) : ANY);
    if (!ab) sent++;
    in_valid <= 1'h0;
    @(posedge pclk);
  endtask : send

  // Waits until the line is idle and every noted byte has gone out
  task idle;
    int n;
    logic [31:0] r;
    logic e;
    for (n = 0; n < 1000; n++) begin
      apb(1'h0, HGF_IDX_LINK_CTRL, 32'h0, r, e);
      if (r[HGF_BUSY_BIT] === 1'h0 && exp_q.size() <= 1) break;
    end
    if (n == 1000) hang("idle");
  endtask : idle

  // Watcher: each taken fill byte adds to the run; each other taken byte settles the oldest note
  always @(posedge pclk) begin
    if (presetn && out_valid === 1'h1 && out_ready === 1'h1) begin
      if (out_fill === 1'h1) begin
        run++;
        chk("fill byte", 32'h7E, {24'h0, out_data});
      end else if (exp_q.size() == 0) chk("spare byte", 32'h0, 32'h1);
      else begin
        if (exp_q[0] >= GAPN) begin
          if (exp_q[0] < ANY) chk("gap flags", exp_q[0] - GAPN, run);
          void'(exp_q.pop_front());
        end
        if (exp_q.size() > 0) chk("line byte", exp_q.pop_front(), {24'h0, out_data});
        else chk("spare byte", 32'h0, 32'h1);
        run = 0;
      end
    end
  end

  // Hang guard over the whole run
  initial begin
    repeat (100000) @(posedge pclk);
    hang("run");
  end

  initial begin
    int i;
    logic [15:0] c;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    exp_q.push_back(ANY);
    rd_chk("link ctrl", HGF_IDX_LINK_CTRL, 32'h0040, 1'h0);
    rd_chk("gap ctrl", HGF_IDX_GAP_CTRL, 32'h0401, 1'h0);
    rd_chk("unmapped", 8'h50, 32'h0, 1'h1);
    wr(HGF_IDX_GAP_CTRL, 16'hFFFF);
    rd_chk("gap ctrl rw", HGF_IDX_GAP_CTRL, 32'h7FFF, 1'h0);
    wr(HGF_IDX_CNT_HI, 16'h0);
    rd_chk("count low", HGF_IDX_CNT_LO, 32'h0, 1'h0);
    // Table of modes, then multiply mode over every scale
    for (i = 0; i < 17; i++) begin
      c = (i < 9) ? CFG[i] : (16'h6000 | 16'((i - 9) << 10));
      idle();
      stall_en <= i[0];
      wr(HGF_IDX_GAP_CTRL, c);
      send((i < 9) ? 6 : 3, 1'h0, c, 1'h1);
      send(4, 1'h0, c, 1'h0);
    end
    send(4, 1'h1, c, 1'h0);
    send(3, 1'h0, c, 1'h0);
    idle();
    wr(HGF_IDX_CNT_HI, 16'h0);
    rd_chk("count low", HGF_IDX_CNT_LO, 32'(sent), 1'h0);
    rd_chk("count high", HGF_IDX_CNT_HI, 32'(sent >> 16), 1'h0);
    rd_chk("count again", HGF_IDX_CNT_LO, 32'(sent), 1'h0);
    // Reading held off: the FIFO fills until it refuses
    wr(HGF_IDX_LINK_CTRL, 16'h0);
    send(8, 1'h0, c, 1'h0);
    repeat (40) @(posedge pclk);
    chk("in_ready full", 32'h0, {31'h0, in_ready});
    rd_chk("level", HGF_IDX_LINK_CTRL, 32'h0800, 1'h0);
    wr(HGF_IDX_LINK_CTRL, 16'h0040);
    idle();
    rd_chk("drained", HGF_IDX_LINK_CTRL, 32'h0040, 1'h0);
    wr(HGF_IDX_CNT_HI, 16'h0);
    rd_chk("count one", HGF_IDX_CNT_LO, 32'h1, 1'h0);
    give_verdict();
  end
endmodule : hgf_top_tb
